// *** verilog/usdc_pkg.sv ***
package usdc_pkg;
  //Function
  //- Select bit 0 feeds PHY regulator from cable bus, 1 from boost.
  //- Bus switch closes only with drive pin high and select bit 1.
  //- Closing the bus switch never starts the boost; its own bit does.
  //- Cold start loads select bit from config pin: open 0, grounded 1.
  //- Grounded config pin also defaults the boost enable bit to 1.
  //- Writing select bit 1 enables PHY regulator and auxiliary regulator.
  //- Bus-valid and session-valid events still flag while boost drives bus.
  //- Open pin: regulator off until bus detected, then on from cable.
  //- Open pin: enable bit powers up 1, forced 1 on reset or bus loss.
  //- Over-voltage disables regulator, disconnects within 1 us, raises interrupt.
  //- Aux voltage field 00/01/10/11 gives 2.400/2.600/2.700/2.775 V.
  //- Bus-valid debounce: rising 20 to 24 ms, falling 8 to 12 ms.
  //- Session-valid debounce: rising 20 to 40 ms, falling 8 to 12 ms.
  //- Each bus comparator has sense bit, mask bit and interrupt pin event.
  //- Pull-up type bit picks current source or resistor; parallel bit adds.
  //- ID senses float,ground,factory: 010 resistor, 000 ground, 110 float, 111 voltage.
  //- Each ID condition has its own pollable sense bit and maskable interrupt.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int VBUS_RISE_MS    = 20;
  localparam int VBUS_FALL_MS    = 8;
  localparam int SESS_RISE_MS    = 20;
  localparam int SESS_FALL_MS    = 8;
  localparam int NS_PER_MS       = 1000000;
  localparam int VBUS_RISE_CYCLES = VBUS_RISE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int VBUS_FALL_CYCLES = VBUS_FALL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int SESS_RISE_CYCLES = SESS_RISE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int SESS_FALL_CYCLES = SESS_FALL_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int OV_DISC_NS      = 1000;
  localparam int OV_DISC_CYCLES  = OV_DISC_NS / CLK_PERIOD_NS;
  localparam int DB_W            = 22;
  localparam int SYN_N           = 9;
  localparam int SYN_VBUS        = 0;
  localparam int SYN_SESS        = 1;
  localparam int SYN_OV          = 2;
  localparam int SYN_IDFL        = 3;
  localparam int SYN_IDGN        = 4;
  localparam int SYN_IDFA        = 5;
  localparam int SYN_DRV         = 6;
  localparam int SYN_CFG         = 7;
  localparam int SYN_SRST        = 8;
  localparam int IRQ_N           = 6;
  localparam int IRQ_VBUS        = 0;
  localparam int IRQ_SESS        = 1;
  localparam int IRQ_OV          = 2;
  localparam int IRQ_IDFL        = 3;
  localparam int IRQ_IDGN        = 4;
  localparam int IRQ_IDFA        = 5;
  localparam logic [1:0]  INIT_WAIT = 2'h3;
  localparam logic [11:0] AUX_MV0   = 12'h0960;
  localparam logic [11:0] AUX_MV1   = 12'h0a28;
  localparam logic [11:0] AUX_MV2   = 12'h0a8c;
  localparam logic [11:0] AUX_MV3   = 12'h0ad7;
  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } usdc_state_e;
endpackage

// *** verilog/usdc_top.sv ***
module usdc_top
  import usdc_pkg::*;
#(
  parameter int VBUS_RISE_CYC = VBUS_RISE_CYCLES,
  parameter int VBUS_FALL_CYC = VBUS_FALL_CYCLES,
  parameter int SESS_RISE_CYC = SESS_RISE_CYCLES,
  parameter int SESS_FALL_CYC = SESS_FALL_CYCLES
)(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             vbus_valid_cmp,
  input  wire logic             session_valid_cmp,
  input  wire logic             overvoltage_cmp,
  input  wire logic             id_float_cmp,
  input  wire logic             id_ground_cmp,
  input  wire logic             id_factory_cmp,
  input  wire logic             bus_drive_enable_pin,
  input  wire logic             startup_config_pin,
  input  wire logic             system_reset_n,
  input  wire logic             otg_select_wr,
  input  wire logic             otg_select_wdata,
  input  wire logic             input_select_wr,
  input  wire logic             input_select_wdata,
  input  wire logic             boost_enable_wr,
  input  wire logic             boost_enable_wdata,
  input  wire logic             phy_enable_wr,
  input  wire logic             phy_enable_wdata,
  input  wire logic             aux_enable_wr,
  input  wire logic             aux_enable_wdata,
  input  wire logic             aux_voltage_wr,
  input  wire logic [1:0]       aux_voltage_wdata,
  input  wire logic             id_pullup_type_in,
  input  wire logic             id_parallel_pullup_in,
  input  wire logic [IRQ_N-1:0] irq_mask,
  input  wire logic [IRQ_N-1:0] irq_clear,
  output logic                  otg_supply_select_ff,
  output logic                  regulator_input_select_ff,
  output logic                  boost_otg_enable_ff,
  output logic                  phy_regulator_enable_ff,
  output logic                  phy_regulator_on_ff,
  output logic                  aux_phy_regulator_enable_ff,
  output logic [1:0]            aux_voltage_sel_ff,
  output logic [11:0]           aux_voltage_mv_ff,
  output logic                  bus_switch_close_ff,
  output logic                  bus_disconnect_ff,
  output logic                  id_pullup_type_ff,
  output logic                  id_parallel_pullup_ff,
  output logic                  vbus_valid_sense_ff,
  output logic                  session_valid_sense_ff,
  output logic                  overvoltage_sense_ff,
  output logic                  id_float_sense_ff,
  output logic                  id_ground_sense_ff,
  output logic                  id_factory_sense_ff,
  output logic [IRQ_N-1:0]      irq_flags_ff,
  output logic                  int_n_ff
);

  logic [SYN_N-1:0] sync1_ff;
  logic [SYN_N-1:0] sync2_ff;
  logic [SYN_N-1:0] raw_in;
  logic [1:0]       deb_ff;
  logic [1:0]       deb_flip;
  logic [DB_W-1:0]  db_cnt_ff [2];
  logic             srst_q_ff;
  logic             cfg_grounded_ff;
  logic [1:0]       init_cnt_ff;
  usdc_state_e      state_ff;
  logic             init_load;
  logic             run;
  logic             force_enable;
  logic [IRQ_N-1:0] irq_evt;

  assign raw_in = {system_reset_n, startup_config_pin, bus_drive_enable_pin,
                   id_factory_cmp, id_ground_cmp, id_float_cmp,
                   overvoltage_cmp, session_valid_cmp, vbus_valid_cmp};

  // Two-stage synchronisers for every pin input
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Cold-start sequencing waits for the synchronised config pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff    <= ST_INIT;
      init_cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_INIT: begin
          if (init_cnt_ff == INIT_WAIT) begin
            state_ff <= ST_RUN;
          end else begin
            init_cnt_ff <= init_cnt_ff + 2'h1;
          end
        end
        ST_RUN: state_ff <= ST_RUN;
        default: state_ff <= ST_INIT;
      endcase
    end
  end

  assign init_load = (state_ff == ST_INIT) && (init_cnt_ff == INIT_WAIT);
  assign run       = (state_ff == ST_RUN);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_grounded_ff <= 1'b0;
    end else if (init_load) begin
      cfg_grounded_ff <= ~sync2_ff[SYN_CFG];
    end
  end

  // Bus comparator debouncers, asymmetric rise and fall times
  genvar ch;
  for (ch = 0; ch < 2; ch++) begin : g_deb
    localparam int RISE_C = (ch == 0) ? VBUS_RISE_CYC : SESS_RISE_CYC;
    localparam int FALL_C = (ch == 0) ? VBUS_FALL_CYC : SESS_FALL_CYC;
    logic            raw;
    logic [DB_W-1:0] lim;
    assign raw = sync2_ff[SYN_VBUS + ch];
    assign lim = deb_ff[ch] ? DB_W'(FALL_C - 1) : DB_W'(RISE_C - 1);
    assign deb_flip[ch] = (raw != deb_ff[ch]) && (db_cnt_ff[ch] == lim);
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        deb_ff[ch]    <= 1'b0;
        db_cnt_ff[ch] <= '0;
      end else if (raw == deb_ff[ch]) begin
        db_cnt_ff[ch] <= '0;
      end else if (deb_flip[ch]) begin
        deb_ff[ch]    <= raw;
        db_cnt_ff[ch] <= '0;
      end else begin
        db_cnt_ff[ch] <= db_cnt_ff[ch] + DB_W'(1);
      end
    end
    deb_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(deb_ff[ch]) |-> $past(db_cnt_ff[ch]) == DB_W'(RISE_C - 1))
      else $error("debounced rise too early");
    deb_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(deb_ff[ch]) |-> $past(db_cnt_ff[ch]) == DB_W'(FALL_C - 1))
      else $error("debounced fall too early");
  end

  // Sense bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vbus_valid_sense_ff    <= 1'b0;
      session_valid_sense_ff <= 1'b0;
      overvoltage_sense_ff   <= 1'b0;
      id_float_sense_ff      <= 1'b0;
      id_ground_sense_ff     <= 1'b0;
      id_factory_sense_ff    <= 1'b0;
      srst_q_ff              <= 1'b0;
    end else begin
      vbus_valid_sense_ff    <= deb_ff[0];
      session_valid_sense_ff <= deb_ff[1];
      overvoltage_sense_ff   <= sync2_ff[SYN_OV];
      id_float_sense_ff      <= sync2_ff[SYN_IDFL];
      id_ground_sense_ff     <= sync2_ff[SYN_IDGN];
      id_factory_sense_ff    <= sync2_ff[SYN_IDFA];
      srst_q_ff              <= sync2_ff[SYN_SRST];
    end
  end

  // Events raised regardless of who drives the bus
  assign irq_evt[IRQ_VBUS] = deb_flip[0];
  assign irq_evt[IRQ_SESS] = deb_flip[1];
  assign irq_evt[IRQ_OV]   = sync2_ff[SYN_OV] & ~overvoltage_sense_ff;
  // ID events wait for run so the synchroniser fill after reset is not flagged
  assign irq_evt[IRQ_IDFL] = run & (sync2_ff[SYN_IDFL] ^ id_float_sense_ff);
  assign irq_evt[IRQ_IDGN] = run & (sync2_ff[SYN_IDGN] ^ id_ground_sense_ff);
  assign irq_evt[IRQ_IDFA] = run & (sync2_ff[SYN_IDFA] ^ id_factory_sense_ff);

  // Sticky flags, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_flags_ff <= '0;
    end else begin
      irq_flags_ff <= (irq_flags_ff & ~irq_clear) | irq_evt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_n_ff <= 1'b1;
    end else begin
      int_n_ff <= ~|(irq_flags_ff & ~irq_mask);
    end
  end

  // Supply selection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      otg_supply_select_ff <= 1'b0;
    end else if (init_load) begin
      otg_supply_select_ff <= ~sync2_ff[SYN_CFG];
    end else if (run && otg_select_wr) begin
      otg_supply_select_ff <= otg_select_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regulator_input_select_ff <= 1'b0;
    end else if (init_load) begin
      regulator_input_select_ff <= ~sync2_ff[SYN_CFG];
    end else if (run && otg_select_wr) begin
      regulator_input_select_ff <= otg_select_wdata;
    end else if (run && input_select_wr) begin
      regulator_input_select_ff <= input_select_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      boost_otg_enable_ff <= 1'b0;
    end else if (init_load) begin
      boost_otg_enable_ff <= ~sync2_ff[SYN_CFG];
    end else if (run && boost_enable_wr) begin
      boost_otg_enable_ff <= boost_enable_wdata;
    end
  end

  // Forced re-enable with open config pin
  assign force_enable = run && !cfg_grounded_ff &&
                        ((sync2_ff[SYN_SRST] & ~srst_q_ff) ||
                         (deb_flip[0] && deb_ff[0]));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phy_regulator_enable_ff <= 1'b0;
    end else if (init_load || force_enable) begin
      phy_regulator_enable_ff <= 1'b1;
    end else if (run && otg_select_wr && otg_select_wdata) begin
      phy_regulator_enable_ff <= 1'b1;
    end else if (run && phy_enable_wr) begin
      phy_regulator_enable_ff <= phy_enable_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aux_phy_regulator_enable_ff <= 1'b0;
    end else if (init_load) begin
      aux_phy_regulator_enable_ff <= ~sync2_ff[SYN_CFG];
    end else if (run && otg_select_wr && otg_select_wdata) begin
      aux_phy_regulator_enable_ff <= 1'b1;
    end else if (run && aux_enable_wr) begin
      aux_phy_regulator_enable_ff <= aux_enable_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aux_voltage_sel_ff <= 2'h0;
    end else if (run && aux_voltage_wr) begin
      aux_voltage_sel_ff <= aux_voltage_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aux_voltage_mv_ff <= AUX_MV0;
    end else begin
      case (aux_voltage_sel_ff)
        2'h0: aux_voltage_mv_ff <= AUX_MV0;
        2'h1: aux_voltage_mv_ff <= AUX_MV1;
        2'h2: aux_voltage_mv_ff <= AUX_MV2;
        2'h3: aux_voltage_mv_ff <= AUX_MV3;
        default: aux_voltage_mv_ff <= AUX_MV0;
      endcase
    end
  end

  // Regulator power, bus switch and over-voltage disconnect
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phy_regulator_on_ff <= 1'b0;
      bus_switch_close_ff <= 1'b0;
      bus_disconnect_ff   <= 1'b0;
    end else begin
      phy_regulator_on_ff <= run && phy_regulator_enable_ff && !sync2_ff[SYN_OV] &&
                             (regulator_input_select_ff || deb_ff[0]);
      bus_switch_close_ff <= sync2_ff[SYN_DRV] && otg_supply_select_ff &&
                             !sync2_ff[SYN_OV];
      bus_disconnect_ff   <= sync2_ff[SYN_OV];
    end
  end

  // Pull-up controls
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      id_pullup_type_ff     <= 1'b0;
      id_parallel_pullup_ff <= 1'b0;
    end else begin
      id_pullup_type_ff     <= id_pullup_type_in;
      id_parallel_pullup_ff <= id_parallel_pullup_in;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  switch_gate_a: assert property (
    bus_switch_close_ff |-> $past(sync2_ff[SYN_DRV]) && $past(otg_supply_select_ff))
    else $error("bus switch closed without drive pin and select");
  boost_alone_a: assert property (
    run && !$past(boost_enable_wr) && $rose(bus_switch_close_ff) |-> $stable(boost_otg_enable_ff))
    else $error("bus switch changed boost enable");
  startup_load_a: assert property (
    init_load |=> otg_supply_select_ff == cfg_grounded_ff && boost_otg_enable_ff == cfg_grounded_ff)
    else $error("start-up defaults not loaded from config pin");
  otg_enables_a: assert property (
    run && otg_select_wr && otg_select_wdata |=>
      phy_regulator_enable_ff && aux_phy_regulator_enable_ff && regulator_input_select_ff)
    else $error("select write did not enable regulators");
  vbus_force_a: assert property (
    run && !cfg_grounded_ff && deb_flip[0] && deb_ff[0] |=> phy_regulator_enable_ff)
    else $error("enable not forced on bus loss");
  cable_off_a: assert property (
    run && !regulator_input_select_ff && !deb_ff[0] |=> !phy_regulator_on_ff)
    else $error("regulator on from cable without bus detect");
  ov_cut_a: assert property (
    $rose(sync2_ff[SYN_OV]) |=> !phy_regulator_on_ff && bus_disconnect_ff && irq_flags_ff[IRQ_OV])
    else $error("over-voltage not acted on");
  flag_hold_a: assert property (
    irq_flags_ff[IRQ_VBUS] && !irq_clear[IRQ_VBUS] |=> irq_flags_ff[IRQ_VBUS])
    else $error("interrupt flag lost without clear");
  set_wins_a: assert property (
    irq_evt[IRQ_SESS] && irq_clear[IRQ_SESS] |=> irq_flags_ff[IRQ_SESS])
    else $error("clear beat simultaneous event");
  int_pin_a: assert property (
    ##1 int_n_ff == !(|($past(irq_flags_ff) & ~$past(irq_mask))))
    else $error("interrupt pin disagrees with flags and mask");
  id_sense_a: assert property (
    run |-> ##2 {id_float_sense_ff, id_ground_sense_ff, id_factory_sense_ff} ==
      $past({id_float_cmp, id_ground_cmp, id_factory_cmp}, 3))
    else $error("id sense bits do not follow comparators");
  aux_code_a: assert property (
    aux_voltage_sel_ff == 2'h3 |=> aux_voltage_mv_ff == AUX_MV3)
    else $error("aux voltage code wrong");

endmodule // usdc_top

// *** verification/usdc_cable_model.sv ***
module usdc_cable_model (
  input  wire logic       attach,
  input  wire logic       ov_in,
  input  wire logic [1:0] id_code,
  output logic            vbus_valid_cmp,
  output logic            session_valid_cmp,
  output logic            overvoltage_cmp,
  output logic [2:0]      id_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both bus comparators follow the cable supply
  assign vbus_valid_cmp    = attach;
  assign session_valid_cmp = attach;
  assign overvoltage_cmp   = ov_in;
  // Float, ground, factory levels per external ID connection
  always_comb begin
    case (id_code)
      2'h0:    id_cmp = 3'h2;
      2'h1:    id_cmp = 3'h0;
      2'h2:    id_cmp = 3'h6;
      default: id_cmp = 3'h7;
    endcase
  end
endmodule // usdc_cable_model

// *** verification/usdc_top_bench.sv ***
module usdc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic sel; logic drv; logic [1:0] av; logic [1:0] id;
    logic sw; logic [11:0] mv; logic [2:0] ids;
  } usdc_row_s;
  localparam usdc_row_s ROWS [4] = '{
    '{1'h0, 1'h1, 2'h0, 2'h0, 1'h0, 12'h0960, 3'h2},
    '{1'h1, 1'h0, 2'h1, 2'h1, 1'h0, 12'h0a28, 3'h0},
    '{1'h1, 1'h1, 2'h2, 2'h2, 1'h1, 12'h0a8c, 3'h6},
    '{1'h0, 1'h0, 2'h3, 2'h3, 1'h0, 12'h0ad7, 3'h7}};
  localparam int W_SEL = 0;
  localparam int W_INS = 1;
  localparam int W_BST = 2;
  localparam int W_PHY = 3;
  localparam int W_AUX = 4;
  localparam int W_AV  = 5;
  logic        sys_clk, rst_n, drv, cfg, srst_n, attach, ov, pt, pp;
  logic        osw, osd, isw, isd, bew, bed, pew, ped, aew, aed, avw;
  logic [1:0]  avd, idc, avs;
  logic [5:0]  msk, clr, flg;
  logic [2:0]  idcmp;
  logic        vcmp, scmp, ocmp, sel_o, ins_o, bst_o, pen_o, pon_o, aen_o;
  logic        sw_o, dis_o, ptq, ppq, vbs, sss, ovs, idf, idg, ida, int_n;
  logic [11:0] mv;
  int          error_cnt, cmp_count, cyc;
  usdc_cable_model i_cable (.attach(attach), .ov_in(ov), .id_code(idc),
    .vbus_valid_cmp(vcmp), .session_valid_cmp(scmp), .overvoltage_cmp(ocmp), .id_cmp(idcmp));
  usdc_top #(.VBUS_RISE_CYC(20), .VBUS_FALL_CYC(8), .SESS_RISE_CYC(30), .SESS_FALL_CYC(10))
  i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .vbus_valid_cmp(vcmp), .session_valid_cmp(scmp),
    .overvoltage_cmp(ocmp), .id_float_cmp(idcmp[2]), .id_ground_cmp(idcmp[1]),
    .id_factory_cmp(idcmp[0]), .bus_drive_enable_pin(drv), .startup_config_pin(cfg),
    .system_reset_n(srst_n), .otg_select_wr(osw), .otg_select_wdata(osd),
    .input_select_wr(isw), .input_select_wdata(isd), .boost_enable_wr(bew),
    .boost_enable_wdata(bed), .phy_enable_wr(pew), .phy_enable_wdata(ped),
    .aux_enable_wr(aew), .aux_enable_wdata(aed), .aux_voltage_wr(avw),
    .aux_voltage_wdata(avd), .id_pullup_type_in(pt), .id_parallel_pullup_in(pp),
    .irq_mask(msk), .irq_clear(clr), .otg_supply_select_ff(sel_o),
    .regulator_input_select_ff(ins_o), .boost_otg_enable_ff(bst_o),
    .phy_regulator_enable_ff(pen_o), .phy_regulator_on_ff(pon_o),
    .aux_phy_regulator_enable_ff(aen_o), .aux_voltage_sel_ff(avs), .aux_voltage_mv_ff(mv),
    .bus_switch_close_ff(sw_o), .bus_disconnect_ff(dis_o), .id_pullup_type_ff(ptq),
    .id_parallel_pullup_ff(ppq), .vbus_valid_sense_ff(vbs), .session_valid_sense_ff(sss),
    .overvoltage_sense_ff(ovs), .id_float_sense_ff(idf), .id_ground_sense_ff(idg),
    .id_factory_sense_ff(ida), .irq_flags_ff(flg), .int_n_ff(int_n));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One write pulse, data copied to every data input
  task automatic wrt(input int w, input logic [1:0] d);
    @(posedge sys_clk);
    {osd, isd, bed, ped, aed} <= {5{d[0]}};
    avd <= d;
    case (w)
      W_SEL:   osw <= 1'h1;
      W_INS:   isw <= 1'h1;
      W_BST:   bew <= 1'h1;
      W_PHY:   pew <= 1'h1;
      W_AUX:   aew <= 1'h1;
      default: avw <= 1'h1;
    endcase
    @(posedge sys_clk);
    {osw, isw, bew, pew, aew, avw} <= 6'h00;
    #1;
  endtask
  task automatic rst(input logic c);
    @(posedge sys_clk);
    rst_n <= 1'h0;
    cfg <= c;
    {attach, ov, drv} <= 3'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    tick(8);
  endtask
  task automatic pulse_clear;
    @(posedge sys_clk);
    clr <= 6'h3f;
    @(posedge sys_clk);
    clr <= 6'h00;
    tick(3);
  endtask
  initial begin
    {rst_n, drv, cfg, attach, ov, pt, pp, osw, osd, isw, isd, bew, bed} = '0;
    {pew, ped, aew, aed, avw, avd, idc, msk, clr} = '0;
    srst_n = 1'h1;
    error_cnt = 0;
    cmp_count = 0;
    rst(1'h1);
    chk({sel_o, bst_o, ins_o, aen_o, pen_o, pon_o}, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      wrt(W_PHY, 2'h0);
      wrt(W_AUX, 2'h0);
      wrt(W_SEL, {1'h0, ROWS[i].sel});
      wrt(W_AV, ROWS[i].av);
      @(posedge sys_clk);
      drv <= ROWS[i].drv;
      idc <= ROWS[i].id;
      pt <= i[0];
      pp <= i[1];
      tick(6);
      chk(sw_o, ROWS[i].sw);
      chk(ins_o, ROWS[i].sel);
      chk({avs, mv}, {ROWS[i].av, ROWS[i].mv});
      chk(bst_o, 1'h0);
      chk({idf, idg, ida}, ROWS[i].ids);
      chk({ppq, ptq}, i[1:0]);
      if (ROWS[i].sel) chk({pen_o, aen_o}, 2'h3);
    end
    pulse_clear();
    chk({int_n, flg}, 7'h40);
    @(posedge sys_clk);
    idc <= 2'h0;
    tick(6);
    chk({int_n, flg}, 7'h28);
    @(posedge sys_clk);
    msk <= 6'h28;
    tick(3);
    chk(int_n, 1'h1);
    rst(1'h1);
    @(posedge sys_clk);
    msk <= 6'h00;
    attach <= 1'h1;
    tick(18);
    chk({vbs, pon_o}, 2'h0);
    tick(10);
    chk({vbs, sss, pon_o}, 3'h5);
    tick(10);
    chk({int_n, sss, flg[1:0]}, 4'h7);
    wrt(W_PHY, 2'h0);
    tick(2);
    chk(pen_o, 1'h0);
    @(posedge sys_clk);
    attach <= 1'h0;
    tick(8);
    chk(vbs, 1'h1);
    tick(8);
    chk({vbs, sss, pen_o}, 3'h1);
    wrt(W_PHY, 2'h0);
    @(posedge sys_clk);
    srst_n <= 1'h0;
    @(posedge sys_clk);
    srst_n <= 1'h1;
    tick(6);
    chk(pen_o, 1'h1);
    rst(1'h0);
    chk({sel_o, bst_o, ins_o, aen_o, pen_o}, 5'h1f);
    @(posedge sys_clk);
    drv <= 1'h1;
    attach <= 1'h1;
    tick(45);
    chk({sw_o, flg[1:0]}, 3'h7);
    wrt(W_PHY, 2'h0);
    wrt(W_INS, 2'h0);
    tick(2);
    chk(pon_o, 1'h0);
    wrt(W_PHY, 2'h1);
    tick(2);
    chk({ins_o, pen_o, pon_o}, 3'h3);
    wrt(W_BST, 2'h0);
    tick(2);
    chk(bst_o, 1'h0);
    wrt(W_BST, 2'h1);
    tick(2);
    chk(bst_o, 1'h1);
    pulse_clear();
    chk(flg, 6'h00);
    @(posedge sys_clk);
    msk <= 6'h3b;
    ov <= 1'h1;
    tick(5);
    chk({dis_o, sw_o, pon_o, flg[2], ovs}, 5'h13);
    chk(int_n, 1'h0);
    // Clear held through both debounced falls: set must still win for a cycle
    @(posedge sys_clk);
    clr <= 6'h3f;
    attach <= 1'h0;
    tick(16);
    chk({vbs, sss, flg}, 8'h00);
    stop_test();
  end
endmodule // usdc_top_bench
